// ==== rtl/uia_pkg.sv ====
// package for the usb interrupt aggregation and sleep block
package uia_pkg;
	localparam int ADDR_W = 6;
	localparam logic [ADDR_W-1:0] OFF_MAIN_FLAGS = 6'h00;
	localparam logic [ADDR_W-1:0] OFF_MAIN_EN = 6'h04;
	localparam logic [ADDR_W-1:0] OFF_OTG_FLAGS = 6'h08;
	localparam logic [ADDR_W-1:0] OFF_OTG_EN = 6'h0c;
	localparam logic [ADDR_W-1:0] OFF_ERR_FLAGS = 6'h10;
	localparam logic [ADDR_W-1:0] OFF_ERR_EN = 6'h14;
	localparam logic [ADDR_W-1:0] OFF_POWER_CTRL = 6'h18;
	localparam logic [ADDR_W-1:0] OFF_POWER_STAT = 6'h1c;
	localparam int FLAG_W = 8;
	localparam int ERR_SUMMARY_BIT = 1;
	localparam int ACTIVITY_BIT = 4;
	localparam int XFER_DONE_BIT = 3;
	localparam logic [7:0] FLAGS_RESET = 8'h00;
	localparam logic [7:0] ENABLES_RESET = 8'h00;
	// power control register fields
	localparam int PC_USB_EN_BIT = 0;
	localparam int PC_SUSPEND_BIT = 1;
	localparam int PC_SHARED_BIT = 2;
	localparam int PC_SUPPLY_BIT = 3;
	localparam int PC_MODE_LSB = 4;
	localparam logic [7:0] POWER_CTRL_RESET = 8'h00;
	typedef enum logic [1:0] {
		UIA_MODE_DEVICE,
		UIA_MODE_HOST,
		UIA_MODE_OTG,
		UIA_MODE_OFF
	} uia_mode_type;
endpackage

// ==== rtl/uia_flag_if.sv ====
// interface carrying one flag group between the top and its flag banks
`timescale 1ns/100ps
interface uia_flag_if #(parameter int W = 8);
	logic [W-1:0] events;
	logic [W-1:0] clear;
	logic [W-1:0] enables;
	logic [W-1:0] flags;
	logic pending;
	modport bank(input events, input clear, input enables, output flags, output pending);
	modport ctrl(output events, output clear, output enables, input flags, input pending);
endinterface

// ==== rtl/uia_flag_bank.sv ====
// one group of sticky event flags with write-one-to-clear and enable gating
`timescale 1ns/100ps
module uia_flag_bank #(
	parameter int W = 8
) (
	input wire logic clk,
	input wire logic rst_n,
	uia_flag_if.bank fb
);
	import uia_pkg::*;
	logic [W-1:0] flags_q;
	logic [W-1:0] flags_d;
	// set wins over a clear in the same cycle; only hardware events set
	assign flags_d = (flags_q & ~fb.clear) | fb.events; // R9
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			flags_q <= W'(FLAGS_RESET);
		end else begin
			flags_q <= flags_d; // R7
		end
	end
	assign fb.flags = flags_q;
	// forwarding follows the current enables at once, so a late enable still raises it
	assign fb.pending = |(flags_q & fb.enables); // R8

	a_flag_sticky: assert property (@(posedge clk) disable iff (!rst_n)
		(flags_q != 0 && fb.clear == 0) |=> ((flags_q & $past(flags_q)) == $past(flags_q))) // R9
		else $error("flag dropped without a clear");
	a_flag_event_sets: assert property (@(posedge clk) disable iff (!rst_n)
		(fb.events != 0) |=> ((flags_q & $past(fb.events)) == $past(fb.events))) // R7
		else $error("event did not set its flag");
endmodule // uia_flag_bank

// ==== rtl/uia_top.sv ====
// usb interrupt aggregation, sleep clock control and supply/id pins
// Functional notes
// R1 - every event source has its own flag and its own enable bit; LINK_ACTIVITY shares otg bit 4 and TRANSFER_DONE main bit 3
// R2 - error summary, main flag bit 1, reads as OR of enabled error flags
// R3 - all enabled flags merge into one request, gated by cpu-side enable
// R4 - top layer: main and otg flags gated by their enable registers
// R5 - second layer: enabled error flags feed the error summary
// R6 - transfer flag set only when transfer completes; MAIN_EVENTS bit 3 also sets it here
// R7 - software writes never set a flag
// R8 - enables gate only forwarding; flags still set and readable
// R9 - flag stays set until software writes one; zero does nothing
// R10 - firmware clears cpu generic usb flag at end of service routine
// R11 - sleep without suspend keeps the usb clock running
// R12 - shared oscillator, sleep without suspend: cpu off, oscillator on
// R13 - separate cpu source disabled on sleep, usb source stays on
// R14 - suspended and shared: oscillator stops when cpu sleeps
// R15 - not shared: oscillator off at suspend, cpu source off at sleep
// R16 - bus activity event enabled automatically on sleep entry
// R17 - firmware sleeps only with usb disabled or link suspended
// R18 - host and otg modes drive supply enable pin from control bit
// R19 - device and otg modes sample the id pin for role select
// R20 - link activity during sleep sets activity flag and wakes chip
// R21 - request is a level while any enabled flag stays set
//
// The Wishbone register port and the address map are this design's own decisions.
`timescale 1ns/100ps
module uia_top #(
	parameter int FLAG_W = 8
) (
	input wire logic CLOCK,
	input wire logic RESETN,
	input wire logic [31:0] WB_ADR_I,
	input wire logic [31:0] WB_DAT_I,
	output logic [31:0] WB_DAT_O,
	input wire logic [3:0] WB_SEL_I,
	input wire logic WB_WE_I,
	input wire logic WB_CYC_I,
	input wire logic WB_STB_I,
	output logic WB_ACK_O,
	input wire logic [FLAG_W-1:0] MAIN_EVENTS,
	input wire logic [FLAG_W-1:0] OTG_EVENTS,
	input wire logic [FLAG_W-1:0] ERROR_EVENTS,
	input wire logic TRANSFER_DONE,
	input wire logic LINK_ACTIVITY,
	input wire logic ID_PIN,
	input wire logic CPU_SLEEP,
	input wire logic CPU_USB_INT_ENABLE,
	output logic USB_REQUEST,
	output logic SUPPLY_ENABLE_OUTPUT,
	output logic USB_CLOCK_ENABLE,
	output logic CPU_CLOCK_ENABLE,
	output logic PRIMARY_OSC_ENABLE,
	output logic CPU_SOURCE_ENABLE,
	output logic WAKE_REQUEST,
	output logic ID_IS_DEVICE
);
	import uia_pkg::*;

	uia_flag_if #(.W(FLAG_W)) main_if ();
	uia_flag_if #(.W(FLAG_W)) otg_if ();
	uia_flag_if #(.W(FLAG_W)) err_if ();

	logic [FLAG_W-1:0] main_en_q, otg_en_q, err_en_q;
	logic [7:0] power_ctrl_q;
	logic ack_q;
	logic [31:0] rdata_q;
	logic [2:0] id_sync_q;
	logic id_q;
	logic [2:0] act_sync_q;
	logic act_q;
	logic sleep_q;
	logic req_q, supply_q, usbclk_q, cpuclk_q, osc_q, cpusrc_q, wake_q;

	// bus decode
	wire bus_req = WB_CYC_I & WB_STB_I & ~ack_q;
	// a write lands at the edge where the master sees ack, address still held
	wire bus_wr = WB_CYC_I & WB_STB_I & ack_q & WB_WE_I & WB_SEL_I[0];
	wire [ADDR_W-1:0] adr = WB_ADR_I[ADDR_W-1:0];
	wire adr_hi_zero = (WB_ADR_I[31:ADDR_W] == '0);
	wire hit_main_f = adr_hi_zero && adr == OFF_MAIN_FLAGS;
	wire hit_main_e = adr_hi_zero && adr == OFF_MAIN_EN;
	wire hit_otg_f = adr_hi_zero && adr == OFF_OTG_FLAGS;
	wire hit_otg_e = adr_hi_zero && adr == OFF_OTG_EN;
	wire hit_err_f = adr_hi_zero && adr == OFF_ERR_FLAGS;
	wire hit_err_e = adr_hi_zero && adr == OFF_ERR_EN;
	wire hit_pc = adr_hi_zero && adr == OFF_POWER_CTRL;
	wire hit_ps = adr_hi_zero && adr == OFF_POWER_STAT;
	wire [FLAG_W-1:0] wmask = WB_DAT_I[FLAG_W-1:0];

	// power settings
	wire usb_en = power_ctrl_q[PC_USB_EN_BIT];
	wire suspend = power_ctrl_q[PC_SUSPEND_BIT];
	wire shared_osc = power_ctrl_q[PC_SHARED_BIT];
	wire supply_bit = power_ctrl_q[PC_SUPPLY_BIT];
	wire [1:0] mode_bits = power_ctrl_q[PC_MODE_LSB+1:PC_MODE_LSB];
	wire host_side = (mode_bits == UIA_MODE_HOST) || (mode_bits == UIA_MODE_OTG);
	wire dev_side = (mode_bits == UIA_MODE_DEVICE) || (mode_bits == UIA_MODE_OTG);

	// activity event: forced enable while sleeping, flag on activity in sleep
	wire act_in_sleep = act_q & sleep_q;
	wire [FLAG_W-1:0] act_bit = FLAG_W'(1) << ACTIVITY_BIT;
	wire [FLAG_W-1:0] otg_en_eff = otg_en_q | (CPU_SLEEP ? act_bit : '0); // R16

	// main events: transfer completion feeds bit 3, summary bit is not a stored flag
	wire [FLAG_W-1:0] sum_bit = FLAG_W'(1) << ERR_SUMMARY_BIT;
	wire [FLAG_W-1:0] xfer_bit = FLAG_W'(1) << XFER_DONE_BIT;
	assign main_if.events = (MAIN_EVENTS | (TRANSFER_DONE ? xfer_bit : '0)) & ~sum_bit; // R6
	assign main_if.clear = (bus_wr && hit_main_f) ? (wmask & ~sum_bit) : '0; // R9
	assign main_if.enables = main_en_q; // R4
	assign otg_if.events = OTG_EVENTS | (act_in_sleep ? act_bit : '0); // R20
	assign otg_if.clear = (bus_wr && hit_otg_f) ? wmask : '0; // R9
	assign otg_if.enables = otg_en_eff; // R4
	assign err_if.events = ERROR_EVENTS;
	assign err_if.clear = (bus_wr && hit_err_f) ? wmask : '0; // R9
	assign err_if.enables = err_en_q; // R5

	uia_flag_bank #(.W(FLAG_W)) u_main (.clk(CLOCK), .rst_n(RESETN), .fb(main_if)); // R1
	uia_flag_bank #(.W(FLAG_W)) u_otg (.clk(CLOCK), .rst_n(RESETN), .fb(otg_if));
	uia_flag_bank #(.W(FLAG_W)) u_err (.clk(CLOCK), .rst_n(RESETN), .fb(err_if));

	// summary is live, never stored, so a write cannot touch it
	wire err_summary = err_if.pending; // R2
	wire main_sum_en = main_en_q[ERR_SUMMARY_BIT];
	wire [FLAG_W-1:0] main_view = main_if.flags | (err_summary ? sum_bit : '0); // R2
	wire any_enabled = main_if.pending | otg_if.pending | (err_summary & main_sum_en); // R3
	wire req_d = any_enabled & CPU_USB_INT_ENABLE; // R21

	wire [31:0] rd_mux =
		hit_main_f ? 32'(main_view) :
		hit_main_e ? 32'(main_en_q) :
		hit_otg_f ? 32'(otg_if.flags) :
		hit_otg_e ? 32'(otg_en_q) :
		hit_err_f ? 32'(err_if.flags) :
		hit_err_e ? 32'(err_en_q) :
		hit_pc ? 32'(power_ctrl_q) :
		hit_ps ? 32'({sleep_q, id_q, osc_q, usbclk_q}) : 32'h0;

	// clock gating decisions
	wire usbclk_d = usb_en & ~suspend; // R11
	wire osc_d = shared_osc ? ~(suspend & CPU_SLEEP) : ~suspend; // R14 R15
	wire cpuclk_d = ~CPU_SLEEP; // R12
	wire cpusrc_d = shared_osc ? osc_d : ~CPU_SLEEP; // R13

	always_ff @(posedge CLOCK or negedge RESETN) begin
		if (!RESETN) begin
			main_en_q <= ENABLES_RESET;
			otg_en_q <= ENABLES_RESET;
			err_en_q <= ENABLES_RESET;
			power_ctrl_q <= POWER_CTRL_RESET;
		end else if (bus_wr) begin
			if (hit_main_e) main_en_q <= wmask;
			if (hit_otg_e) otg_en_q <= wmask;
			if (hit_err_e) err_en_q <= wmask;
			if (hit_pc) power_ctrl_q <= WB_DAT_I[7:0];
		end
	end

	always_ff @(posedge CLOCK or negedge RESETN) begin
		if (!RESETN) begin
			ack_q <= 1'b0;
			rdata_q <= 32'h0;
		end else begin
			ack_q <= bus_req;
			rdata_q <= bus_req ? rd_mux : 32'h0;
		end
	end

	// pin synchronisers: change accepted when stages two and three agree
	always_ff @(posedge CLOCK or negedge RESETN) begin
		if (!RESETN) begin
			id_sync_q <= 3'h0;
			id_q <= 1'b0;
			act_sync_q <= 3'h0;
			act_q <= 1'b0;
			sleep_q <= 1'b0;
		end else begin
			id_sync_q <= {id_sync_q[1:0], ID_PIN};
			if (id_sync_q[2] == id_sync_q[1] && dev_side) id_q <= id_sync_q[2]; // R19
			act_sync_q <= {act_sync_q[1:0], LINK_ACTIVITY};
			// activity counts once stages two and three agree, as for the id pin
			if (act_sync_q[2] == act_sync_q[1]) act_q <= act_sync_q[2]; // R20
			sleep_q <= CPU_SLEEP;
		end
	end

	always_ff @(posedge CLOCK or negedge RESETN) begin
		if (!RESETN) begin
			req_q <= 1'b0;
			supply_q <= 1'b0;
			usbclk_q <= 1'b0;
			cpuclk_q <= 1'b1;
			osc_q <= 1'b1;
			cpusrc_q <= 1'b1;
			wake_q <= 1'b0;
		end else begin
			req_q <= req_d; // R3
			supply_q <= usb_en & host_side & supply_bit; // R18
			usbclk_q <= usbclk_d;
			cpuclk_q <= cpuclk_d;
			osc_q <= osc_d;
			cpusrc_q <= cpusrc_d;
			wake_q <= sleep_q & otg_if.flags[ACTIVITY_BIT]; // R20
		end
	end

	assign WB_ACK_O = ack_q;
	assign WB_DAT_O = rdata_q;
	assign USB_REQUEST = req_q;
	assign SUPPLY_ENABLE_OUTPUT = supply_q;
	assign USB_CLOCK_ENABLE = usbclk_q;
	assign CPU_CLOCK_ENABLE = cpuclk_q;
	assign PRIMARY_OSC_ENABLE = osc_q;
	assign CPU_SOURCE_ENABLE = cpusrc_q;
	assign WAKE_REQUEST = wake_q;
	assign ID_IS_DEVICE = id_q;

	a_request_level: assert property (@(posedge CLOCK) disable iff (!RESETN)
		(any_enabled && CPU_USB_INT_ENABLE) |=> USB_REQUEST) // R21
		else $error("request missing while enabled flag set");
	a_request_drops: assert property (@(posedge CLOCK) disable iff (!RESETN)
		(!any_enabled) |=> !USB_REQUEST) // R3
		else $error("request held with no enabled flag");
	a_summary_or: assert property (@(posedge CLOCK) disable iff (!RESETN)
		main_view[ERR_SUMMARY_BIT] == |(err_if.flags & err_en_q)) // R2
		else $error("summary does not match enabled errors");
	a_usb_clock_kept: assert property (@(posedge CLOCK) disable iff (!RESETN)
		(usb_en && !suspend && CPU_SLEEP) |=> USB_CLOCK_ENABLE) // R11
		else $error("usb clock stopped in sleep");
	a_osc_shared_stop: assert property (@(posedge CLOCK) disable iff (!RESETN)
		(shared_osc && suspend && CPU_SLEEP) |=> !PRIMARY_OSC_ENABLE) // R14
		else $error("shared oscillator kept in suspended sleep");
	a_osc_split_stop: assert property (@(posedge CLOCK) disable iff (!RESETN)
		(!shared_osc && suspend) |=> !PRIMARY_OSC_ENABLE) // R15
		else $error("oscillator kept during suspend");
	a_cpu_source_off: assert property (@(posedge CLOCK) disable iff (!RESETN)
		(!shared_osc && CPU_SLEEP) |=> !CPU_SOURCE_ENABLE) // R13
		else $error("cpu source kept in sleep");
	a_supply_pin: assert property (@(posedge CLOCK) disable iff (!RESETN)
		(usb_en && host_side && supply_bit) |=> SUPPLY_ENABLE_OUTPUT) // R18
		else $error("supply pin not driven");
	a_activity_wake: assert property (@(posedge CLOCK) disable iff (!RESETN)
		(act_q && sleep_q && CPU_SLEEP) |=> ##1 (otg_if.flags[ACTIVITY_BIT] && (WAKE_REQUEST || !CPU_SLEEP))) // R20
		else $error("activity in sleep did not flag and wake");

	// bus handshake
	a_ack_single: assert property (@(posedge CLOCK) disable iff (!RESETN)
		WB_ACK_O |=> !WB_ACK_O)
		else $error("ack held for more than one cycle");
	a_rdata_idle: assert property (@(posedge CLOCK) disable iff (!RESETN)
		!WB_ACK_O |-> (WB_DAT_O == 32'h0))
		else $error("read data shown without ack");

	// flag groups: only hardware sets, a written one clears
	a_main_no_set: assert property (@(posedge CLOCK) disable iff (!RESETN)
		(main_if.events == '0) |=> ((main_if.flags & ~$past(main_if.flags)) == '0)) // R7
		else $error("main flag set without an event");
	a_otg_no_set: assert property (@(posedge CLOCK) disable iff (!RESETN)
		(otg_if.events == '0) |=> ((otg_if.flags & ~$past(otg_if.flags)) == '0)) // R7
		else $error("otg flag set without an event");
	a_err_no_set: assert property (@(posedge CLOCK) disable iff (!RESETN)
		(err_if.events == '0) |=> ((err_if.flags & ~$past(err_if.flags)) == '0)) // R7
		else $error("error flag set without an event");
	a_main_clear: assert property (@(posedge CLOCK) disable iff (!RESETN)
		(main_if.clear != '0 && main_if.events == '0) |=> ((main_if.flags & $past(main_if.clear)) == '0)) // R9
		else $error("main flag not cleared by a written one");
	a_err_clear: assert property (@(posedge CLOCK) disable iff (!RESETN)
		(err_if.clear != '0 && err_if.events == '0) |=> ((err_if.flags & $past(err_if.clear)) == '0)) // R9
		else $error("error flag not cleared by a written one");
	a_summary_unstored: assert property (@(posedge CLOCK) disable iff (!RESETN)
		main_if.flags[ERR_SUMMARY_BIT] == 1'b0) // R2
		else $error("summary bit stored as a flag");
	a_xfer_flag: assert property (@(posedge CLOCK) disable iff (!RESETN)
		TRANSFER_DONE |=> main_if.flags[XFER_DONE_BIT]) // R6
		else $error("transfer completion did not set its flag");
	a_disabled_flag_kept: assert property (@(posedge CLOCK) disable iff (!RESETN)
		(main_if.events != '0 && main_en_q == '0) |=> ((main_if.flags & $past(main_if.events)) == $past(main_if.events))) // R8
		else $error("disabled flag not set by its event");

	// request forwarding
	a_request_gated: assert property (@(posedge CLOCK) disable iff (!RESETN)
		!CPU_USB_INT_ENABLE |=> !USB_REQUEST) // R3
		else $error("request raised while cpu side disabled");
	a_summary_request: assert property (@(posedge CLOCK) disable iff (!RESETN)
		(err_summary && main_sum_en && CPU_USB_INT_ENABLE) |=> USB_REQUEST) // R5
		else $error("enabled error did not raise the request");

	// sleep clocks and pins
	a_cpu_clock_sleep: assert property (@(posedge CLOCK) disable iff (!RESETN)
		CPU_SLEEP |=> !CPU_CLOCK_ENABLE) // R12
		else $error("cpu clock kept in sleep");
	a_osc_shared_kept: assert property (@(posedge CLOCK) disable iff (!RESETN)
		(shared_osc && !suspend) |=> PRIMARY_OSC_ENABLE) // R12
		else $error("shared oscillator stopped without suspend");
	a_usb_source_kept: assert property (@(posedge CLOCK) disable iff (!RESETN)
		(!shared_osc && !suspend && CPU_SLEEP) |=> PRIMARY_OSC_ENABLE) // R13
		else $error("usb clock source stopped in sleep");
	a_activity_forced: assert property (@(posedge CLOCK) disable iff (!RESETN)
		CPU_SLEEP |-> otg_if.enables[ACTIVITY_BIT]) // R16
		else $error("activity event not enabled in sleep");
	a_supply_off: assert property (@(posedge CLOCK) disable iff (!RESETN)
		!(usb_en && host_side && supply_bit) |=> !SUPPLY_ENABLE_OUTPUT) // R18
		else $error("supply pin driven when not selected");
	a_id_held: assert property (@(posedge CLOCK) disable iff (!RESETN)
		!dev_side |=> $stable(ID_IS_DEVICE)) // R19
		else $error("id level changed outside device modes");
	a_id_follows: assert property (@(posedge CLOCK) disable iff (!RESETN)
		(dev_side && id_sync_q[2] == id_sync_q[1]) |=> (ID_IS_DEVICE == $past(id_sync_q[2]))) // R19
		else $error("settled id level not taken");
	a_wake_needs_sleep: assert property (@(posedge CLOCK) disable iff (!RESETN)
		!sleep_q |=> !WAKE_REQUEST) // R20
		else $error("wake raised outside sleep");
endmodule // uia_top

// ==== tb/uia_cpu_model.sv ====
// cpu interrupt flag register and service routine facing the usb request
`timescale 1ns/100ps
module uia_cpu_model (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic usb_request,
	input wire logic service_done,
	output logic int_flag
);
	logic [31:0] cpu_flags_q;
	// bit 25 holds the generic request until the service routine ends
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cpu_flags_q <= 32'h0;
		end else if (service_done) begin
			cpu_flags_q[25] <= 1'b0;
		end else if (usb_request) begin
			cpu_flags_q[25] <= 1'b1;
		end
	end
	assign int_flag = cpu_flags_q[25];
endmodule // uia_cpu_model

// ==== tb/uia_top_test.sv ====
// self-checking bench for the usb interrupt aggregation block
`timescale 1ns/100ps
module uia_top_test;
	import uia_pkg::*;
	logic clk, rst_n, cyc, stb, we, xfer, link, id, slp, ien, ack, req, sup, uclk, cclk, osc, csrc, wake, idd, svc, fw;
	logic [31:0] adr, wdat, rdat, rd;
	logic [3:0] sel;
	logic [7:0] mev, oev, eev, m, o, e, v;
	logic [6:0] i;
	integer miscompares = 0, total_checks = 0, cycles = 0, seed = 32636;
	integer fl[3], en[3];
	logic ide, ox;
	uia_top u_dut(.CLOCK(clk), .RESETN(rst_n), .WB_ADR_I(adr), .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_SEL_I(sel),
		.WB_WE_I(we), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_ACK_O(ack), .MAIN_EVENTS(mev), .OTG_EVENTS(oev),
		.ERROR_EVENTS(eev), .TRANSFER_DONE(xfer), .LINK_ACTIVITY(link), .ID_PIN(id), .CPU_SLEEP(slp),
		.CPU_USB_INT_ENABLE(ien), .USB_REQUEST(req), .SUPPLY_ENABLE_OUTPUT(sup), .USB_CLOCK_ENABLE(uclk),
		.CPU_CLOCK_ENABLE(cclk), .PRIMARY_OSC_ENABLE(osc), .CPU_SOURCE_ENABLE(csrc), .WAKE_REQUEST(wake),
		.ID_IS_DEVICE(idd));
	uia_cpu_model u_cpu(.clk(clk), .rst_n(rst_n), .usb_request(req), .service_done(svc), .int_flag(fw));
	task automatic tally_and_finish;
		$display("checks=%0d mismatches=%0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	// one classic cycle; read data taken at the ack edge only
	task automatic bus(input logic w, input int a, input logic [7:0] d);
		@(posedge clk);
		{cyc, stb, we} <= {2'b11, w};
		adr <= 32'(a);
		wdat <= {24'h0, d};
		@(posedge clk);
		// only the bench timeout ends a wait that never sees ack
		while (ack !== 1'b1) begin
			@(posedge clk);
		end
		rd = rdat;
		{cyc, stb, we} <= 3'b000;
	endtask
	task automatic verify;
		int s, r;
		s = ((fl[2] & en[2]) != 0);
		r = ien && ((((fl[0] | (s << 1)) & en[0]) | (fl[1] & en[1])) != 0);
		repeat (3) @(posedge clk);
		chk({31'h0, req}, 32'(r));
		for (int g = 0; g < 3; g++) begin
			bus(0, g * 8, 8'h00);
			chk(rd, 32'((g == 0) ? (fl[0] | (s << 1)) : fl[g]));
		end
	endtask
	initial begin
		clk = 0;
		forever #12.5 clk = ~clk;
	end
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			miscompares++;
			tally_and_finish;
		end
	end
	initial begin
		{rst_n, cyc, stb, we, xfer, link, id, slp, ien, svc} = '0;
		{mev, oev, eev, adr, wdat} = '0;
		sel = 4'hf;
		ide = 0;
		repeat (5) @(posedge clk);
		rst_n <= 1;
		for (int a = 0; a < 9; a++) begin
			bus(0, a * 4, 8'h00);
			chk(rd, (a == 7) ? 32'h2 : 32'h0);
		end
		bus(1, 8'h20, 8'hff);
		fl = '{0, 0, 0};
		$display("reset values done");
		for (i = 0; i < 10; i++) begin
			ien <= 1'($random(seed));
			for (int g = 0; g < 3; g++) begin
				en[g] = $random(seed) & 8'hff;
				bus(1, g * 8 + 4, 8'(en[g]));
			end
			{m, o, e} = 24'($random(seed));
			m = m & 8'hfd;
			@(posedge clk);
			{mev, oev, eev, xfer} <= {m, o, e, i[0]};
			@(posedge clk);
			{mev, oev, eev, xfer} <= '0;
			fl[0] = fl[0] | m | (i[0] ? 8 : 0);
			fl[1] = fl[1] | o;
			fl[2] = fl[2] | e;
			verify;
			for (int g = 0; g < 3; g++) begin
				v = (i == 3) ? 8'h00 : 8'($random(seed));
				bus(1, g * 8, v);
				fl[g] = fl[g] & ~v;
			end
			verify;
		end
		for (int g = 0; g < 3; g++) begin
			en[g] = 8'hff;
			bus(1, g * 8 + 4, 8'hff);
		end
		ien <= 1;
		@(posedge clk);
		oev <= 8'h01;
		@(posedge clk);
		oev <= 8'h00;
		repeat (3) @(posedge clk);
		chk({31'h0, fw}, 32'h1);
		for (int g = 0; g < 3; g++) bus(1, g * 8, 8'hff);
		fl = '{0, 0, 0};
		svc <= 1;
		@(posedge clk);
		svc <= 0;
		verify;
		chk({31'h0, fw}, 32'h0);
		$display("flag aggregation done");
		for (i = 0; i < 64; i++) begin
			bus(1, OFF_POWER_CTRL, {2'b00, i[4:3], i[5], i[0], i[1], 1'b1});
			// sleep follows i[2] whatever the suspend bit i[1] holds, usb left enabled
			slp <= i[2];
			id <= 1'($random(seed));
			repeat (8) @(posedge clk);
			if (i[4:3] == 2'd0 || i[4:3] == 2'd2) ide = id;
			ox = i[0] ? !(i[1] & i[2]) : !i[1];
			chk({31'h0, uclk}, {31'h0, !i[1]});
			chk({31'h0, osc}, {31'h0, ox});
			chk({31'h0, csrc}, {31'h0, i[0] ? ox : !i[2]});
			chk({31'h0, cclk}, {31'h0, !i[2]});
			chk({31'h0, sup}, {31'h0, i[5] && (i[4:3] == 1 || i[4:3] == 2)});
			chk({31'h0, idd}, {31'h0, ide});
		end
		$display("power and pins done");
		for (int g = 0; g < 3; g++) bus(1, g * 8 + 4, 8'h00);
		bus(1, OFF_POWER_CTRL, 8'h03);
		slp <= 1;
		repeat (3) @(posedge clk);
		link <= 1;
		repeat (3) @(posedge clk);
		link <= 0;
		repeat (5) @(posedge clk);
		chk({31'h0, wake}, 32'h1);
		chk({31'h0, req}, 32'h1);
		bus(0, OFF_OTG_FLAGS, 8'h00);
		chk(rd, 32'h10);
		slp <= 0;
		bus(1, OFF_OTG_FLAGS, 8'h10);
		repeat (3) @(posedge clk);
		chk({31'h0, wake | req}, 32'h0);
		$display("sleep wake done");
		tally_and_finish;
	end
endmodule // uia_top_test
